// file: bench/lm_host.sv
// far-side host model: drives operand, instruction and result-latch pins
`timescale 1ns/1ps
module lm_host
   import lm_pkg::*;
(
   // clock
   input wire logic pclk,
   // operand and instruction pins
   output logic input_strobe_n,
   output logic x_load_en_n,
   output logic y_load_en_n,
   output logic [LM_OPW-1:0] x_in,
   output logic [LM_OPW-1:0] y_in,
   output logic x_signed_sel,
   output logic y_signed_sel,
   output logic round_ctl,
   output logic shift_bypass,
   output logic pass_through_sel,
   // result latch control
   output logic output_strobe,
   output logic result_load_en_n
);
   initial begin
      input_strobe_n = 1'b1;
      x_load_en_n = 1'b1;
      y_load_en_n = 1'b1;
      x_in = 16'h0000;
      y_in = 16'h0000;
      {pass_through_sel, shift_bypass, round_ctl, y_signed_sel, x_signed_sel} = 5'h00;
      output_strobe = 1'b0;
      result_load_en_n = 1'b1;
   end

   ////////////////////////////////////////
   // ins is {ld, fa, rnd, ym, xm}
   task automatic op(input logic [15:0] x, input logic [15:0] y, input logic [4:0] ins,
                     input logic xe_n, input logic ye_n, input logic we_n);
      @(posedge pclk);
      x_in <= x;
      y_in <= y;
      {pass_through_sel, shift_bypass, round_ctl, y_signed_sel, x_signed_sel} <= ins;
      input_strobe_n <= 1'b0;
      x_load_en_n <= xe_n;
      y_load_en_n <= ye_n;
      @(posedge pclk);
      // released lines flip so a leaky latch shows
      x_in <= ~x;
      y_in <= ~y;
      {pass_through_sel, shift_bypass, round_ctl, y_signed_sel, x_signed_sel} <= ~ins;
      input_strobe_n <= 1'b1;
      x_load_en_n <= 1'b1;
      y_load_en_n <= 1'b1;
      output_strobe <= 1'b1;
      result_load_en_n <= we_n;
      @(posedge pclk);
      output_strobe <= 1'b0;
      result_load_en_n <= 1'b1;
   endtask
endmodule

// file: bench/tb_latched_16x16_multiplier.sv
// testbench: multiplier datapath against a behavioural model
`timescale 1ns/1ps
module tb_latched_16x16_multiplier
   import lm_pkg::*;
   ;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [LM_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic input_strobe_n, x_load_en_n, y_load_en_n, x_signed_sel, y_signed_sel;
   logic round_ctl, shift_bypass, pass_through_sel, output_strobe, result_load_en_n;
   logic half_select, upper_drive_off_n, lower_drive_off_n, upper_out_oe_n, lower_out_oe_n;
   logic zero_flag, sign_flag, overflow_flag;
   logic [LM_OPW-1:0] x_in, y_in, upper_out_field, lower_out_field, m_x, m_y;
   logic [4:0] m_ins;
   logic [34:0] m_res;
   logic [36:0] tbl [8];
   int n_mismatch = 0;
   int num_checks = 0;

   initial pclk = 1'b0;
   always #2 pclk = ~pclk;

   lm_mult u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .input_strobe_n(input_strobe_n), .x_load_en_n(x_load_en_n), .y_load_en_n(y_load_en_n),
      .x_in(x_in), .y_in(y_in), .x_signed_sel(x_signed_sel), .y_signed_sel(y_signed_sel),
      .round_ctl(round_ctl), .shift_bypass(shift_bypass), .pass_through_sel(pass_through_sel),
      .output_strobe(output_strobe), .result_load_en_n(result_load_en_n), .half_select(half_select),
      .upper_drive_off_n(upper_drive_off_n), .lower_drive_off_n(lower_drive_off_n),
      .upper_out_field(upper_out_field), .upper_out_oe_n(upper_out_oe_n),
      .lower_out_field(lower_out_field), .lower_out_oe_n(lower_out_oe_n),
      .zero_flag(zero_flag), .sign_flag(sign_flag), .overflow_flag(overflow_flag));

   lm_host u_host (.pclk(pclk), .input_strobe_n(input_strobe_n), .x_load_en_n(x_load_en_n),
      .y_load_en_n(y_load_en_n), .x_in(x_in), .y_in(y_in), .x_signed_sel(x_signed_sel),
      .y_signed_sel(y_signed_sel), .round_ctl(round_ctl), .shift_bypass(shift_bypass),
      .pass_through_sel(pass_through_sel), .output_strobe(output_strobe),
      .result_load_en_n(result_load_en_n));

   ////////////////////////////////////////
   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // pready and read data taken at the rising edge that completes the access
   task automatic apb(input logic wr, input logic [LM_AW-1:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         n_mismatch++;
         end_of_test;
      end
      rdat = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // returns {ovf, sign, zero, w}
   function automatic logic [34:0] model();
      longint px, py;
      logic [31:0] z, w;
      logic ov, ze;
      px = m_ins[0] ? longint'($signed(m_x)) : longint'(m_x);
      py = m_ins[1] ? longint'($signed(m_y)) : longint'(m_y);
      z = m_ins[4] ? {m_x, m_y} : 32'(px * py);
      w = m_ins[3] ? z : {z[30:0], 1'b0};
      if (m_ins[2]) w = w + 32'h0000_8000;
      ov = m_ins[4] ? (m_ins[0] && z == 32'h8000_0000)
         : (&m_ins[1:0] && m_x == 16'h8000 && m_y == 16'h8000 && !m_ins[3]);
      ze = !ov && (m_ins[2] ? (m_ins[3] ? z[31:16] == 16'h0 : z[31:15] == 17'h0) : z == 32'h0);
      return {ov, (m_ins[4] ? m_ins[0] : |m_ins[1:0]) & z[31], ze, w};
   endfunction

   // sw set: operands come from software registers, pins carry the inverse
   task automatic run(input logic [15:0] x, input logic [15:0] y, input logic [4:0] ins,
                      input logic xe_n, input logic ye_n, input logic we_n, input logic sw);
      logic [31:0] w;
      logic [31:0] exp [4];
      logic hs, uo, lo;
      if (sw) begin
         apb(1'b1, LM_ADDR_OPND, {y, x}, rd, err);
         apb(1'b1, LM_ADDR_INSTR, {23'h0, 1'b1, 3'h0, ins}, rd, err);
      end
      u_host.op(sw ? ~x : x, sw ? ~y : y, sw ? ~ins : ins, xe_n, ye_n, we_n);
      if (!xe_n) {m_x, m_ins[0]} = {x, ins[0]};
      if (!ye_n) {m_y, m_ins[1]} = {y, ins[1]};
      if (!(xe_n && ye_n)) m_ins[4:2] = ins[4:2];
      if (!we_n) m_res = model();
      {hs, uo, lo} = 3'($urandom);
      half_select <= hs;
      upper_drive_off_n <= uo;
      lower_drive_off_n <= lo;
      @(negedge pclk);
      w = m_res[31:0];
      chk({upper_out_field, lower_out_field}, {hs ? w[15:0] : w[31:16], w[15:0]});
      chk(32'({upper_out_oe_n, lower_out_oe_n}), 32'({uo, lo}));
      chk(32'({overflow_flag, sign_flag, zero_flag}), 32'(m_res[34:32]));
      exp = '{{m_y, m_x}, {23'h0, sw, 3'h0, m_ins}, w, 32'(m_res[34:32])};
      foreach (exp[i]) begin
         apb(1'b0, 8'(4 * i), 32'h0, rd, err);
         chk(rd, exp[i]);
      end
      if (sw) begin
         apb(1'b1, LM_ADDR_INSTR, 32'h0, rd, err);
      end
   endtask

   ////////////////////////////////////////
   initial begin
      #80000;
      $display("watchdog expired");
      n_mismatch++;
      end_of_test;
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      half_select = 1'b0;
      upper_drive_off_n = 1'b1;
      lower_drive_off_n = 1'b1;
      {m_x, m_y, m_ins, m_res} = '0;
      // x, y, {ld, fa, rnd, ym, xm}
      tbl = '{{16'h8000, 16'h8000, 5'h03}, {16'h8000, 16'h8000, 5'h0B}, {16'h8000, 16'h0000, 5'h11},
              {16'h0000, 16'h8000, 5'h1C}, {16'h0000, 16'h8000, 5'h14}, {16'hFFFF, 16'h0002, 5'h01},
              {16'hFFFF, 16'hFFFF, 5'h00}, {16'h0001, 16'h0001, 5'h04}};
      void'($urandom(32'hC0552B63));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, LM_ADDR_INSTR, 32'h0, rd, err);
      chk(32'(err), 32'h0);
      apb(1'b1, LM_ADDR_RESULT, 32'hFFFF_FFFF, rd, err);
      apb(1'b0, LM_ADDR_RESULT, 32'h0, rd, err);
      chk(rd, 32'h0);
      apb(1'b0, 8'h10, 32'h0, rd, err);
      chk(32'(err), 32'h1);
      $display("test reset_bus done");
      foreach (tbl[i]) run(tbl[i][36:21], tbl[i][20:5], tbl[i][4:0], 1'b0, 1'b0, 1'b0, 1'b0);
      $display("test corners done");
      // partial enables exercise every hold path
      repeat (24) run(16'($urandom), 16'($urandom), 5'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 1'b0);
      $display("test hold done");
      for (int i = 0; i < 32; i++) run(16'($urandom), 16'($urandom), 5'(i), 1'b0, 1'b0, 1'b0, 1'b0);
      $display("test modes done");
      repeat (8) run(16'($urandom), 16'($urandom), 5'($urandom), 1'b0, 1'b0, 1'b0, 1'b1);
      $display("test software source done");
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      {m_x, m_y, m_ins, m_res} = '0;
      run(16'($urandom), 16'($urandom), 5'($urandom), 1'b1, 1'b1, 1'b1, 1'b0);
      $display("test mid reset done");
      end_of_test;
   end
endmodule

// file: design/lm_mult.sv
// design: latched 16x16 multiplier datapath with apb status/control
//
// Operation
// - x latch loads when strobe and x enable low
// - y latch loads when strobe and y enable low
// - sign-mode bit picks twos-complement, stored with data
// - result format follows operands; mixed gives signed
// - instruction latch loads when strobe low, any enable
// - result split into high and low halves
// - round adds one at low half top bit
// - shift bypass high passes array result unshifted
// - shift bypass low shifts left one, zero fill
// - pass-through low multiplies latched operands
// - pass-through high concatenates x over y
// - pass-through signedness from x sign-mode bit
// - no round: zero flag tests whole result
// - round: zero tests bits 31:16 or 31:15
// - zero never set with overflow
// - multiply overflow only signed full-neg squared, shifted
// - sign flag only for negative signed result
// - loaded 8000_0000 signed sets sign and overflow
// - result and flags load on strobe high, enable low
// - each output field has own async drive-off
// - upper field: high half, or low when selected
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module lm_mult
   import lm_pkg::*;
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [LM_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // operand and instruction pins
   input wire logic input_strobe_n,
   input wire logic x_load_en_n,
   input wire logic y_load_en_n,
   input wire logic [LM_OPW-1:0] x_in,
   input wire logic [LM_OPW-1:0] y_in,
   input wire logic x_signed_sel,
   input wire logic y_signed_sel,
   input wire logic round_ctl,
   input wire logic shift_bypass,
   input wire logic pass_through_sel,
   // result latch control
   input wire logic output_strobe,
   input wire logic result_load_en_n,
   // output fields
   input wire logic half_select,
   input wire logic upper_drive_off_n,
   input wire logic lower_drive_off_n,
   output logic [LM_OPW-1:0] upper_out_field,
   output logic upper_out_oe_n,
   output logic [LM_OPW-1:0] lower_out_field,
   output logic lower_out_oe_n,
   // flags
   output logic zero_flag,
   output logic sign_flag,
   output logic overflow_flag
);

   ////////////////////////////////////////////////////////////////////////////
   // software-side operand and instruction registers

   logic [31:0] opnd_reg_ff;
   logic [31:0] instr_reg_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;

   wire apb_setup = psel & ~penable;
   wire apb_done = psel & penable & pready_ff;
   wire hit_opnd = (paddr == LM_ADDR_OPND);
   wire hit_instr = (paddr == LM_ADDR_INSTR);
   wire hit_result = (paddr == LM_ADDR_RESULT);
   wire hit_flags = (paddr == LM_ADDR_FLAGS);
   wire hit_any = hit_opnd | hit_instr | hit_result | hit_flags;
   wire wr_opnd = apb_done & pwrite & hit_opnd;
   wire wr_instr = apb_done & pwrite & hit_instr;
   wire sw_src = instr_reg_ff[LM_B_SWSRC];

   ////////////////////////////////////////////////////////////////////////////
   // latch input selection: pins, or software registers when sw_src set

   lm_operand_t x_src;
   lm_operand_t y_src;
   lm_instr_t i_src;

   assign x_src.signed_sel = sw_src ? instr_reg_ff[LM_B_XM] : x_signed_sel;
   assign x_src.data = sw_src ? opnd_reg_ff[LM_OPW-1:0] : x_in;
   assign y_src.signed_sel = sw_src ? instr_reg_ff[LM_B_YM] : y_signed_sel;
   assign y_src.data = sw_src ? opnd_reg_ff[LM_OPND_Y_LSB +: LM_OPW] : y_in;
   assign i_src.round_ctl = sw_src ? instr_reg_ff[LM_B_RND] : round_ctl;
   assign i_src.shift_bypass = sw_src ? instr_reg_ff[LM_B_FA] : shift_bypass;
   assign i_src.pass_through_sel = sw_src ? instr_reg_ff[LM_B_LD] : pass_through_sel;

   ////////////////////////////////////////////////////////////////////////////
   // input and instruction latches, one clocked load per transparent cycle

   lm_operand_t x_ff;
   lm_operand_t y_ff;
   lm_instr_t instr_ff;

   wire x_open = ~input_strobe_n & ~x_load_en_n;
   wire y_open = ~input_strobe_n & ~y_load_en_n;
   wire i_open = ~input_strobe_n & (~x_load_en_n | ~y_load_en_n);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         x_ff <= '0;
         y_ff <= '0;
         instr_ff <= '0;
      end else begin
         // sign-mode travels with its operand data
         if (x_open) begin
            x_ff <= x_src;
         end
         if (y_open) begin
            y_ff <= y_src;
         end
         if (i_open) begin
            instr_ff <= i_src;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // array: multiply or pass-through

   // one extra top bit per operand makes unsigned and signed share one multiplier
   wire signed [LM_OPW:0] x_ext = {x_ff.signed_sel & x_ff.data[LM_OPW-1], x_ff.data};
   wire signed [LM_OPW:0] y_ext = {y_ff.signed_sel & y_ff.data[LM_OPW-1], y_ff.data};
   wire signed [LM_PRODW-1:0] prod = x_ext * y_ext;
   wire [LM_RESW-1:0] z_res = instr_ff.pass_through_sel ? {x_ff.data, y_ff.data}
                                                        : prod[LM_RESW-1:0];
   // mixed formats come out signed; pass-through takes x's mode alone
   wire z_signed = instr_ff.pass_through_sel ? x_ff.signed_sel
                                             : (x_ff.signed_sel | y_ff.signed_sel);

   ////////////////////////////////////////////////////////////////////////////
   // format adjust and round

   wire [LM_RESW-1:0] z_adj = instr_ff.shift_bypass ? z_res : {z_res[LM_RESW-2:0], 1'b0};
   wire [LM_RESW-1:0] w_next = instr_ff.round_ctl ? (z_adj + LM_ROUND_ADD) : z_adj;

   ////////////////////////////////////////////////////////////////////////////
   // flags from the intermediate result

   wire ovf_mult = ~instr_ff.pass_through_sel & x_ff.signed_sel & y_ff.signed_sel &
                   (x_ff.data == LM_FULL_NEG) & (y_ff.data == LM_FULL_NEG) &
                   ~instr_ff.shift_bypass;
   wire ovf_load = instr_ff.pass_through_sel & x_ff.signed_sel & (z_res == LM_OVF_PATTERN);
   wire ovf_next = ovf_mult | ovf_load;
   wire zero_full = (z_res == '0);
   wire zero_hi16 = (z_res[LM_RESW-1:LM_HALF_HI] == '0);
   wire zero_hi17 = (z_res[LM_RESW-1:LM_HALF_LO] == '0);
   wire zero_rnd = instr_ff.shift_bypass ? zero_hi16 : zero_hi17;
   wire zero_next = (instr_ff.round_ctl ? zero_rnd : zero_full) & ~ovf_next;
   wire sign_next = z_signed & z_res[LM_RESW-1];

   lm_flags_t flags_next;
   assign flags_next.zero = zero_next;
   assign flags_next.sign = sign_next;
   assign flags_next.ovf = ovf_next;

   ////////////////////////////////////////////////////////////////////////////
   // result and flag latch

   logic [LM_RESW-1:0] w_ff;
   lm_flags_t flags_ff;
   wire w_open = output_strobe & ~result_load_en_n;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         w_ff <= '0;
         flags_ff <= '0;
      end else if (w_open) begin
         w_ff <= w_next;
         flags_ff <= flags_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output fields

   wire [LM_OPW-1:0] high_half = w_ff[LM_RESW-1:LM_HALF_HI];
   wire [LM_OPW-1:0] low_half = w_ff[LM_OPW-1:0];

   // mux and drive-off act without the clock, so they sit after the flops
   assign upper_out_field = half_select ? low_half : high_half;
   assign lower_out_field = low_half;
   assign upper_out_oe_n = upper_drive_off_n;
   assign lower_out_oe_n = lower_drive_off_n;
   assign zero_flag = flags_ff.zero;
   assign sign_flag = flags_ff.sign;
   assign overflow_flag = flags_ff.ovf;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: read data captured in setup, answer in first access cycle

   wire [31:0] instr_rd = {instr_reg_ff[31:LM_B_SWSRC], 3'h0,
                           instr_ff.pass_through_sel, instr_ff.shift_bypass,
                           instr_ff.round_ctl, y_ff.signed_sel, x_ff.signed_sel};
   wire [31:0] flags_rd = {29'h0, flags_ff.ovf, flags_ff.sign, flags_ff.zero};
   wire [31:0] opnd_rd = {y_ff.data, x_ff.data};
   wire [31:0] rd_mux = hit_opnd ? opnd_rd :
                        hit_instr ? instr_rd :
                        hit_result ? w_ff :
                        hit_flags ? flags_rd : LM_RST_WORD;
   wire [31:0] nxt_instr_reg = {23'h0, pwdata[LM_B_SWSRC], 3'h0, pwdata[LM_B_LD:LM_B_XM]};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= LM_RST_WORD;
      end else begin
         pready_ff <= apb_setup;
         pslverr_ff <= apb_setup & ~hit_any;
         if (apb_setup) begin
            prdata_ff <= pwrite ? LM_RST_WORD : rd_mux;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opnd_reg_ff <= LM_RST_WORD;
         instr_reg_ff <= LM_RST_WORD;
      end else begin
         if (wr_opnd) begin
            opnd_reg_ff <= pwdata;
         end
         if (wr_instr) begin
            instr_reg_ff <= nxt_instr_reg;
         end
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   x_latch_load_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      x_open |=> (x_ff == $past(x_src)))
      else $error("x latch did not load when open");

   x_latch_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !x_open |=> $stable(x_ff))
      else $error("x latch changed while closed");

   y_latch_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !y_open |=> $stable(y_ff))
      else $error("y latch changed while closed");

   instr_latch_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (input_strobe_n || (x_load_en_n && y_load_en_n)) |=> $stable(instr_ff))
      else $error("instruction latch changed while closed");

   result_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !w_open |=> ($stable(w_ff) && $stable(flags_ff)))
      else $error("result latch changed while closed");

   mult_unshifted_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (w_open && !instr_ff.pass_through_sel && instr_ff.shift_bypass && !instr_ff.round_ctl)
      |=> (w_ff == $past(prod[LM_RESW-1:0])))
      else $error("unshifted product not latched");

   pass_concat_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (w_open && instr_ff.pass_through_sel && !instr_ff.shift_bypass && !instr_ff.round_ctl)
      |=> (w_ff == {$past(x_ff.data[LM_OPW-2:0]), $past(y_ff.data), 1'b0}))
      else $error("pass-through shift wrong");

   round_add_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (w_open && instr_ff.round_ctl) |=> (w_ff == $past(z_adj) + LM_ROUND_ADD))
      else $error("rounding add wrong");

   zero_ovf_excl_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !(zero_flag && overflow_flag))
      else $error("zero with overflow");

   ovf_cause_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (w_open && !instr_ff.pass_through_sel) |=> (overflow_flag == $past(x_ff.signed_sel && y_ff.signed_sel &&
         (x_ff.data == LM_FULL_NEG) && (y_ff.data == LM_FULL_NEG) && !instr_ff.shift_bypass)))
      else $error("overflow flag wrong");

   sign_cause_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      w_open |=> (sign_flag == $past(z_res[LM_RESW-1] &&
         (instr_ff.pass_through_sel ? x_ff.signed_sel : (x_ff.signed_sel || y_ff.signed_sel)))))
      else $error("sign flag wrong");

   zero_full_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (w_open && !instr_ff.round_ctl && !ovf_next) |=> (zero_flag == ($past(z_res) == '0)))
      else $error("zero flag wrong without round");

   upper_mux_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      upper_out_field == (half_select ? w_ff[LM_OPW-1:0] : w_ff[LM_RESW-1:LM_HALF_HI]))
      else $error("upper field mux wrong");

   apb_answer_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      apb_setup |=> pready ##1 !pready)
      else $error("apb answer timing wrong");

   y_latch_load_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      y_open |=> (y_ff == $past(y_src)))
      else $error("y latch did not load when open");

   instr_latch_load_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      i_open |=> (instr_ff == $past(i_src)))
      else $error("instruction latch did not load when open");

   shift_fill_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (w_open && !instr_ff.shift_bypass && !instr_ff.round_ctl) |=>
         (w_ff == {$past(z_res[LM_RESW-2:0]), 1'b0}))
      else $error("format shift wrong");

   zero_round_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (w_open && instr_ff.round_ctl && !ovf_next) |=> (zero_flag == ($past(instr_ff.shift_bypass) ?
         ($past(z_res[LM_RESW-1:LM_HALF_HI]) == '0) : ($past(z_res[LM_RESW-1:LM_HALF_LO]) == '0))))
      else $error("zero flag wrong with round");

   mixed_sign_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (w_open && !instr_ff.pass_through_sel && (x_ff.signed_sel != y_ff.signed_sel)) |=>
         (sign_flag == $past((x_ff.signed_sel ? x_ff.data[LM_OPW-1] : y_ff.data[LM_OPW-1]) &&
         (x_ff.data != '0) && (y_ff.data != '0))))
      else $error("mixed format result not signed");

   load_ovf_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (w_open && instr_ff.pass_through_sel && x_ff.signed_sel && (z_res == LM_OVF_PATTERN)) |=>
         (overflow_flag && sign_flag))
      else $error("loaded overflow pattern not flagged");

   lower_field_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      lower_out_field == w_ff[LM_OPW-1:0])
      else $error("lower field not low half");

   drive_off_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (upper_out_oe_n == upper_drive_off_n) && (lower_out_oe_n == lower_drive_off_n))
      else $error("drive-off not passed to field");

   apb_error_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (apb_setup && !hit_any) |=> (pready && pslverr))
      else $error("unmapped address not refused");

   sw_source_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (x_open && sw_src) |=> (x_ff == {$past(instr_reg_ff[LM_B_XM]), $past(opnd_reg_ff[LM_OPW-1:0])}))
      else $error("x latch ignored software source");

endmodule

// file: shared/lm_pkg.sv
// package: constants and carriers for the latched 16x16 multiplier
package lm_pkg;
   localparam int LM_OPW = 16;
   localparam int LM_RESW = 32;
   localparam int LM_PRODW = 34;
   localparam int LM_HALF_LO = 15;
   localparam int LM_HALF_HI = 16;
   localparam logic [LM_RESW-1:0] LM_ROUND_ADD = 32'h0000_8000;
   localparam logic [LM_OPW-1:0] LM_FULL_NEG = 16'h8000;
   localparam logic [LM_RESW-1:0] LM_OVF_PATTERN = 32'h8000_0000;
   // apb register byte addresses
   localparam int LM_AW = 8;
   localparam logic [LM_AW-1:0] LM_ADDR_OPND = 8'h00;
   localparam logic [LM_AW-1:0] LM_ADDR_INSTR = 8'h04;
   localparam logic [LM_AW-1:0] LM_ADDR_RESULT = 8'h08;
   localparam logic [LM_AW-1:0] LM_ADDR_FLAGS = 8'h0C;
   // instr register fields
   localparam int LM_B_XM = 0;
   localparam int LM_B_YM = 1;
   localparam int LM_B_RND = 2;
   localparam int LM_B_FA = 3;
   localparam int LM_B_LD = 4;
   localparam int LM_B_SWSRC = 8;
   // flags register fields
   localparam int LM_B_ZERO = 0;
   localparam int LM_B_SIGN = 1;
   localparam int LM_B_OVF = 2;
   localparam int LM_OPND_Y_LSB = 16;
   localparam logic [31:0] LM_RST_WORD = 32'h0000_0000;

   typedef struct packed {
      logic signed_sel;
      logic [LM_OPW-1:0] data;
   } lm_operand_t;

   typedef struct packed {
      logic round_ctl;
      logic shift_bypass;
      logic pass_through_sel;
   } lm_instr_t;

   typedef struct packed {
      logic zero;
      logic sign;
      logic ovf;
   } lm_flags_t;
endpackage
